//--- ccr_host.sv
// Host controller model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
    // Device side of the data pin
    input  wire logic ser_data_out,
    input  wire logic ser_data_oe_n,
    // Serial pins
    output logic      ser_clk,
    output logic      ser_cs_n,
    output logic      ser_data_in
);
    logic host_d;
    // Pin level: device when enabled, else host; released bits toggle, no pull
    assign ser_data_in = !ser_data_oe_n ? ser_data_out : host_d;
    initial begin
        ser_clk = 1'b0;
        ser_cs_n = 1'b1;
        host_d = 1'b0;
    end
    // One word MSB first; cut stops after that many rising edges
    task automatic xfer(input logic [13:0] w, input int cut, output logic [7:0] rd);
        rd = 8'h00;
        ser_cs_n = 1'b0;
        for (int k = 13; k >= 0; k--) begin
            if (13 - k < cut) begin
                host_d = (w[13:12] == 2'h2 && k < 8) ? ~host_d : w[k]; // Released on read
                #400 ser_clk = 1'b1; // Device samples here
                #400 if (k < 8) rd[k] = ser_data_in;
                ser_clk = 1'b0;
            end
        end
        #400 ser_cs_n = 1'b1; // High between words
        host_d = ~host_d;
        #1200;
    endtask
endmodule
`default_nettype wire

//--- ccr_pkg.sv
// Package for the codec control register bank: addresses, fields, defaults, framing
package ccr_pkg;
    // Serial word framing
    localparam int        WORD_BITS      = 14;
    localparam logic [3:0] WORD_LAST     = 4'hD;  // Index of 14th edge (0-based)
    localparam logic [3:0] ADDR_END_IDX  = 4'h5;  // Edges before the dummy bit done
    localparam logic [1:0] INSTR_READ    = 2'h2;
    localparam logic [1:0] INSTR_WRITE   = 2'h3;
    // Register addresses
    localparam logic [2:0] ADDR_PWR_FMT  = 3'h4;
    localparam logic [2:0] ADDR_TONE_MUTE = 3'h5;
    localparam logic [2:0] ADDR_GUARD    = 3'h6;
    // Power and format fields
    localparam int BIT_CODEC0_PD   = 0;
    localparam int BIT_CODEC1_PD   = 1;
    localparam int BIT_TONE_RX0_PD = 2;
    localparam int BIT_TONE_RX1_PD = 3;
    localparam int BIT_FIRST_FS    = 4;
    localparam int BIT_SLOT_SEL    = 5;
    localparam int BIT_FMT_LO      = 6;
    localparam int BIT_FMT_HI      = 7;
    // Tone, mute and law fields
    localparam int BIT_TONE0_FREQ  = 0;
    localparam int BIT_TONE1_FREQ  = 1;
    localparam int BIT_OUT0_MUTE   = 2;
    localparam int BIT_OUT1_MUTE   = 3;
    localparam int BIT_LAW         = 4;
    localparam logic [7:0] TONE_MUTE_MASK = 8'h1F;
    // Guard field positions
    localparam int GUARD_PRES_LSB  = 0;
    localparam int GUARD_ABS_LSB   = 4;
    // Reset values
    localparam logic [7:0] PWR_FMT_RST   = 8'h00;
    localparam logic [7:0] TONE_MUTE_RST = 8'h10;
    localparam logic [7:0] GUARD_RST     = 8'h00;
endpackage

//--- ccr_regbank.sv
// Codec control register bank with three-wire serial port
// What this block does
// - Codec channel power-down bit 1 powers channel off, 0 on; both reset to 0.
// - Tone receiver power-down bits sit at positions 2 and 3 of power/format.
// - Bit 4 of power/format picks first frame sync: 0 channel 0, 1 channel 1.
// - Bit 5 of power/format assigns slots; default 0 puts channel 0 first.
// - Each tone generator has a frequency bit: 0 low tone, 1 high tone; reset 0.
// - Mute bits 2 and 3 silence the PCM transmit output of their channel.
// - Bit 4 of tone/mute picks law: 0 A-law, 1 mu-law; resets to 1.
// - Tone-present guard time is bits 0..3 of guard register, read back as written.
// - Tone-absent guard time is bits 4..7 of guard register, read back as written.
// - Word is 14 bits MSB first: instruction, address, dummy, eight data bits.
// - Data sampled on rising clocks after select falls; write commits on 14th rise.
// - Select rising early discards a write or abandons a read.
// - Defaults load only at power-on reset; otherwise host programs all registers.
`timescale 1ns/1ps
`default_nettype none
module ccr_regbank
    import ccr_pkg::*;
(
    // Clock and power-on reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Serial port pins
    input  wire logic ser_clk,
    input  wire logic ser_cs_n,
    input  wire logic ser_data_in,
    output logic      ser_data_out,
    output logic      ser_data_oe_n,
    // PCM transmit data from codec core
    input  wire logic pcm_tx_in_ch0,
    input  wire logic pcm_tx_in_ch1,
    // Frame sync inputs
    input  wire logic frame_sync_ch0,
    input  wire logic frame_sync_ch1,
    // Power controls
    output logic      codec_ch0_power_down,
    output logic      codec_ch1_power_down,
    output logic      tone_rx0_power_down,
    output logic      tone_rx1_power_down,
    // PCM format controls
    output logic      first_frame_sync_select,
    output logic      first_frame_sync,
    output logic      slot_assignment_select,
    output logic      pcm_format_select_lo,
    output logic      pcm_format_select_hi,
    // Tone, mute and law controls
    output logic      tone0_frequency_select,
    output logic      tone1_frequency_select,
    output logic      pcm_out0_mute,
    output logic      pcm_out1_mute,
    output logic      pcm_tx_out_ch0,
    output logic      pcm_tx_out_ch1,
    output logic      companding_law_select,
    // Guard time fields
    output logic [3:0] tone_present_guard_field,
    output logic [3:0] tone_absent_guard_field
);
    typedef enum logic [2:0] {
        CCR_IDLE  = 3'b001,
        CCR_SHIFT = 3'b010,
        CCR_DRIVE = 3'b100
    } ccr_state_t;

    logic [2:0]  pins_s;
    logic        sclk_d_r;
    logic        cs_d_r;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic        sdi;
    ccr_state_t  state_r;
    logic [3:0]  rise_cnt_r;
    logic [3:0]  fall_cnt_r;
    logic [12:0] shift_r;
    logic [1:0]  instr_r;
    logic [2:0]  addr_r;
    logic [7:0]  rd_shift_r;
    logic [7:0]  pwr_fmt_r;
    logic [7:0]  tone_mute_r;
    logic [7:0]  guard_r;
    logic [7:0]  rd_word;

    // Read-back mux with unused bits forced to zero
    function automatic logic [7:0] read_reg(input logic [2:0] a, input logic [7:0] pf,
                                            input logic [7:0] tm, input logic [7:0] gd);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_PWR_FMT:   v = pf;
            ADDR_TONE_MUTE: v = tm & TONE_MUTE_MASK;
            ADDR_GUARD:     v = gd;
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    // Serial pins come from the host's clock domain
    ccr_sync #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     ({ser_clk, ser_cs_n, ser_data_in}),
        .dout    (pins_s)
    );

    assign sdi = pins_s[0];

    // Word for the addressed register, ready before the read starts
    assign rd_word = read_reg(addr_r, pwr_fmt_r, tone_mute_r, guard_r);

    // Edge history of synchronised clock and select
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b0;  // Matches synchroniser reset; no false select fall
        end else begin
            sclk_d_r <= pins_s[2];
            cs_d_r   <= pins_s[1];
        end
    end

    assign sclk_rise = pins_s[2] & ~sclk_d_r;
    assign sclk_fall = ~pins_s[2] & sclk_d_r;
    assign cs_rise   = pins_s[1] & ~cs_d_r;
    assign cs_fall   = ~pins_s[1] & cs_d_r;

    // Frame sequencer; select high always returns to idle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= CCR_IDLE;
            rise_cnt_r <= 4'h0;
            fall_cnt_r <= 4'h0;
            shift_r    <= 13'h0000;
            instr_r    <= 2'h0;
            addr_r     <= 3'h0;
        end else if (cs_rise || pins_s[1]) begin
            state_r    <= CCR_IDLE;
            rise_cnt_r <= 4'h0;
            fall_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                CCR_IDLE: begin
                    // Only a fresh select edge opens a frame; a held low does not
                    if (cs_fall) begin
                        state_r    <= CCR_SHIFT;
                        rise_cnt_r <= 4'h0;
                        fall_cnt_r <= 4'h0;
                    end
                end
                CCR_SHIFT: begin
                    if (sclk_rise) begin
                        shift_r    <= {shift_r[11:0], sdi};
                        rise_cnt_r <= rise_cnt_r + 4'h1;
                        if (rise_cnt_r == ADDR_END_IDX) begin
                            instr_r <= shift_r[4:3];
                            addr_r  <= shift_r[2:0];
                        end
                        if (rise_cnt_r == WORD_LAST) begin
                            state_r <= CCR_DRIVE;  // Wait out remaining clocks
                        end
                    end
                    if (sclk_fall) begin
                        fall_cnt_r <= fall_cnt_r + 4'h1;
                    end
                end
                CCR_DRIVE: begin
                    if (sclk_fall && fall_cnt_r != 4'hF) begin
                        fall_cnt_r <= fall_cnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // Register writes on the 14th rising edge only; defaults at power-on reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwr_fmt_r   <= PWR_FMT_RST;
            tone_mute_r <= TONE_MUTE_RST;
            guard_r     <= GUARD_RST;
        end else if (state_r == CCR_SHIFT && sclk_rise && !pins_s[1]
                     && rise_cnt_r == WORD_LAST && instr_r == INSTR_WRITE) begin
            unique case (addr_r)
                ADDR_PWR_FMT:   pwr_fmt_r   <= {shift_r[6:0], sdi};
                ADDR_TONE_MUTE: tone_mute_r <= {shift_r[6:0], sdi} & TONE_MUTE_MASK;
                ADDR_GUARD:     guard_r     <= {shift_r[6:0], sdi};
                default:        ;  // Addresses outside this bank ignored
            endcase
        end
    end

    // Read data: load after dummy bit sampled, shift on each later falling edge through the 13th
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_shift_r    <= 8'h00;
            ser_data_out  <= 1'b0;
            ser_data_oe_n <= 1'b1;
        end else if (pins_s[1] || state_r == CCR_IDLE) begin
            ser_data_oe_n <= 1'b1;
            ser_data_out  <= 1'b0;
        end else if (sclk_fall && instr_r == INSTR_READ) begin
            // Dummy bit was the 6th rising edge; D7 goes out on the 6th falling edge
            if (fall_cnt_r == ADDR_END_IDX) begin
                rd_shift_r    <= {rd_word[6:0], 1'b0};
                ser_data_out  <= rd_word[7];
                ser_data_oe_n <= 1'b0;
            end else if (fall_cnt_r > ADDR_END_IDX && fall_cnt_r < WORD_LAST) begin
                ser_data_out <= rd_shift_r[7];
                rd_shift_r   <= {rd_shift_r[6:0], 1'b0};
            end else if (fall_cnt_r == WORD_LAST) begin
                ser_data_oe_n <= 1'b1;  // Released on the 14th falling edge
                ser_data_out  <= 1'b0;
            end
        end
    end

    // Frame sync pins from outside; two flops before use
    logic fs0_m_r;
    logic fs0_s_r;
    logic fs1_m_r;
    logic fs1_s_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fs0_m_r <= 1'b0;
            fs0_s_r <= 1'b0;
            fs1_m_r <= 1'b0;
            fs1_s_r <= 1'b0;
        end else begin
            fs0_m_r <= frame_sync_ch0;
            fs0_s_r <= fs0_m_r;
            fs1_m_r <= frame_sync_ch1;
            fs1_s_r <= fs1_m_r;
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            codec_ch0_power_down     <= 1'b0;
            codec_ch1_power_down     <= 1'b0;
            tone_rx0_power_down      <= 1'b0;
            tone_rx1_power_down      <= 1'b0;
            first_frame_sync_select  <= 1'b0;
            first_frame_sync         <= 1'b0;
            slot_assignment_select   <= 1'b0;
            pcm_format_select_lo     <= 1'b0;
            pcm_format_select_hi     <= 1'b0;
            tone0_frequency_select   <= 1'b0;
            tone1_frequency_select   <= 1'b0;
            pcm_out0_mute            <= 1'b0;
            pcm_out1_mute            <= 1'b0;
            companding_law_select    <= 1'b1;
            tone_present_guard_field <= 4'h0;
            tone_absent_guard_field  <= 4'h0;
        end else begin
            codec_ch0_power_down     <= pwr_fmt_r[BIT_CODEC0_PD];
            codec_ch1_power_down     <= pwr_fmt_r[BIT_CODEC1_PD];
            tone_rx0_power_down      <= pwr_fmt_r[BIT_TONE_RX0_PD];
            tone_rx1_power_down      <= pwr_fmt_r[BIT_TONE_RX1_PD];
            first_frame_sync_select  <= pwr_fmt_r[BIT_FIRST_FS];
            first_frame_sync         <= pwr_fmt_r[BIT_FIRST_FS] ? fs1_s_r : fs0_s_r;
            slot_assignment_select   <= pwr_fmt_r[BIT_SLOT_SEL];
            pcm_format_select_lo     <= pwr_fmt_r[BIT_FMT_LO];
            pcm_format_select_hi     <= pwr_fmt_r[BIT_FMT_HI];
            tone0_frequency_select   <= tone_mute_r[BIT_TONE0_FREQ];
            tone1_frequency_select   <= tone_mute_r[BIT_TONE1_FREQ];
            pcm_out0_mute            <= tone_mute_r[BIT_OUT0_MUTE];
            pcm_out1_mute            <= tone_mute_r[BIT_OUT1_MUTE];
            companding_law_select    <= tone_mute_r[BIT_LAW];
            tone_present_guard_field <= guard_r[GUARD_PRES_LSB +: 4];
            tone_absent_guard_field  <= guard_r[GUARD_ABS_LSB +: 4];
        end
    end

    // Muted channels send zeros; core data is same-clock logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pcm_tx_out_ch0 <= 1'b0;
            pcm_tx_out_ch1 <= 1'b0;
        end else begin
            pcm_tx_out_ch0 <= pcm_tx_in_ch0 & ~tone_mute_r[BIT_OUT0_MUTE];
            pcm_tx_out_ch1 <= pcm_tx_in_ch1 & ~tone_mute_r[BIT_OUT1_MUTE];
        end
    end
endmodule
`default_nettype wire

//--- ccr_regbank_properties.sv
// Port-level checks for the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_regbank_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Serial pins
    input wire logic       ser_cs_n,
    input wire logic       ser_data_oe_n,
    // PCM path
    input wire logic       pcm_tx_in_ch0,
    input wire logic       pcm_tx_in_ch1,
    input wire logic       pcm_out0_mute,
    input wire logic       pcm_out1_mute,
    input wire logic       pcm_tx_out_ch0,
    input wire logic       pcm_tx_out_ch1,
    // Frame sync
    input wire logic       frame_sync_ch0,
    input wire logic       frame_sync_ch1,
    input wire logic       first_frame_sync_select,
    input wire logic       first_frame_sync,
    // Law and guard fields
    input wire logic       companding_law_select,
    input wire logic [3:0] tone_present_guard_field,
    input wire logic [3:0] tone_absent_guard_field
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Select idle long enough for the synchroniser and turnaround
    sequence cs_idle_s; ser_cs_n [*6]; endsequence
    // Select idle long enough for any landed write to reach the pins
    sequence quiet_s; ser_cs_n [*8]; endsequence
    // Sync inputs and selection held still past the two-flop delay
    sequence fs_steady_s;
        ($stable(frame_sync_ch0) && $stable(frame_sync_ch1) && $stable(first_frame_sync_select)) [*5];
    endsequence
    a_rst_defaults: assert property ($rose(reset_n) |-> companding_law_select
        && tone_present_guard_field == 4'h0 && tone_absent_guard_field == 4'h0 && !pcm_out0_mute)
        else $error("defaults not present after reset");
    a_mute0_zero: assert property (pcm_out0_mute && $past(pcm_out0_mute) |-> !pcm_tx_out_ch0)
        else $error("muted channel 0 not silent");
    a_mute1_zero: assert property (pcm_out1_mute && $past(pcm_out1_mute) |-> !pcm_tx_out_ch1)
        else $error("muted channel 1 not silent");
    a_pass0_data: assert property (!pcm_out0_mute && !$past(pcm_out0_mute) && $past(reset_n)
        |-> pcm_tx_out_ch0 == $past(pcm_tx_in_ch0)) else $error("channel 0 data not passed");
    a_pass1_data: assert property (!pcm_out1_mute && !$past(pcm_out1_mute) && $past(reset_n)
        |-> pcm_tx_out_ch1 == $past(pcm_tx_in_ch1)) else $error("channel 1 data not passed");
    a_oe_idle: assert property (cs_idle_s |-> ser_data_oe_n)
        else $error("data pin driven with select high");
    a_oe_start: assert property ($fell(ser_data_oe_n) |-> !ser_cs_n && $past(!ser_cs_n, 4))
        else $error("data pin driven outside a frame");
    a_ctrl_quiet: assert property (quiet_s |-> $stable(tone_present_guard_field)
        && $stable(tone_absent_guard_field) && $stable(companding_law_select))
        else $error("control changed with no frame");
    a_fs_pick: assert property (fs_steady_s |-> first_frame_sync ==
        (first_frame_sync_select ? frame_sync_ch1 : frame_sync_ch0)) else $error("wrong first sync");
endmodule
bind ccr_regbank ccr_regbank_chk i_chk (.*);
`default_nettype wire

//--- ccr_regbank_tb.sv
// Self-checking bench for the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_regbank_tb;
    import ccr_pkg::*;
    logic clk_sys, reset_n, pcm_tx_in_ch0, pcm_tx_in_ch1, frame_sync_ch0, frame_sync_ch1;
    logic ser_clk, ser_cs_n, ser_data_in, ser_data_out, ser_data_oe_n, first_frame_sync;
    logic codec_ch0_power_down, codec_ch1_power_down, tone_rx0_power_down, tone_rx1_power_down;
    logic first_frame_sync_select, slot_assignment_select, pcm_format_select_lo;
    logic pcm_format_select_hi, tone0_frequency_select, tone1_frequency_select;
    logic pcm_out0_mute, pcm_out1_mute, pcm_tx_out_ch0, pcm_tx_out_ch1, companding_law_select;
    logic [3:0] tone_present_guard_field, tone_absent_guard_field;
    logic [7:0] exp_q[$];
    logic [7:0] seen, v, r;
    event       seen_ev;
    int         failures, n_compared;
    ccr_regbank i_dut (.*);
    ccr_host i_host (.ser_data_out(ser_data_out), .ser_data_oe_n(ser_data_oe_n),
        .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data_in(ser_data_in));
    // 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pairs each result with the oldest note
    initial forever begin
        @(seen_ev);
        check(seen, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
    end
    task automatic observe(input logic [7:0] e, input logic [7:0] got);
        exp_q.push_back(e);
        seen = got;
        -> seen_ev;
        #1;
    endtask
    task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
        i_host.xfer({INSTR_READ, a, 9'h000}, 14, r);
        observe(e, r);
    endtask
    task automatic wr(input logic [1:0] ins, input logic [2:0] a, input logic [7:0] d, input int cut);
        i_host.xfer({ins, a, 1'b0, d}, cut, r);
    endtask
    // Register fields as they show on the control pins
    function automatic logic [7:0] pins(input logic [2:0] a);
        if (a == ADDR_PWR_FMT) return {pcm_format_select_hi, pcm_format_select_lo,
            slot_assignment_select, first_frame_sync_select, tone_rx1_power_down,
            tone_rx0_power_down, codec_ch1_power_down, codec_ch0_power_down};
        if (a == ADDR_TONE_MUTE) return {3'h0, companding_law_select, pcm_out1_mute,
            pcm_out0_mute, tone1_frequency_select, tone0_frequency_select};
        return {tone_absent_guard_field, tone_present_guard_field};
    endfunction
    task automatic do_reset();
        @(negedge clk_sys) reset_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic end_of_test();
        if (exp_q.size() != 0) failures++;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        $display("[ERR] %0t run did not finish", $time);
        end_of_test();
    end
    initial begin
        {reset_n, pcm_tx_in_ch0, pcm_tx_in_ch1, frame_sync_ch0, frame_sync_ch1} = 5'h00;
        void'($urandom(32'hD550));
        do_reset();
        rd_exp(ADDR_PWR_FMT, PWR_FMT_RST); // Power bits on
        rd_exp(ADDR_TONE_MUTE, TONE_MUTE_RST); // Law and tones
        rd_exp(ADDR_GUARD, GUARD_RST); // Guard fields
        observe(TONE_MUTE_RST, pins(ADDR_TONE_MUTE)); // Pins at reset
        rd_exp(3'h7, 8'h00); // Unmapped place
        $display("defaults test done");
        for (int i = 0; i < 6; i++) begin
            for (int a = 4; a < 7; a++) begin
                v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
                wr(INSTR_WRITE, 3'(a), v, 14); // Commit on last rise
                rd_exp(3'(a), a == 5 ? v & TONE_MUTE_MASK : v); // Read back
                observe(a == 5 ? v & TONE_MUTE_MASK : v, pins(3'(a))); // Pins
            end
            @(negedge clk_sys) {pcm_tx_in_ch0, pcm_tx_in_ch1} = 2'($urandom);
            {frame_sync_ch0, frame_sync_ch1} = 2'($urandom);
            repeat (6) @(negedge clk_sys);
            observe({6'h00, pcm_tx_in_ch1 & ~pcm_out1_mute, pcm_tx_in_ch0 & ~pcm_out0_mute},
                {6'h00, pcm_tx_out_ch1, pcm_tx_out_ch0}); // Mute gate
            observe({7'h00, first_frame_sync_select ? frame_sync_ch1 : frame_sync_ch0},
                {7'h00, first_frame_sync}); // Sync pick
        end
        $display("field test done");
        wr(INSTR_WRITE, ADDR_GUARD, 8'h5A, 14);
        wr(2'h0, ADDR_GUARD, 8'hA5, 14);
        wr(2'h1, ADDR_GUARD, 8'hA5, 14);
        wr(INSTR_WRITE, ADDR_GUARD, 8'hA5, 13);
        rd_exp(ADDR_GUARD, 8'h5A); // No action and cut write
        i_host.xfer({INSTR_READ, ADDR_GUARD, 9'h000}, 10, r);
        rd_exp(ADDR_GUARD, 8'h5A); // After cut read
        wr(INSTR_WRITE, 3'h7, 8'hFF, 14);
        rd_exp(3'h7, 8'h00); // Unmapped write dropped
        $display("refusal test done");
        do_reset();
        rd_exp(ADDR_GUARD, GUARD_RST); // Defaults again
        rd_exp(ADDR_TONE_MUTE, TONE_MUTE_RST); // Law back to one
        $display("second reset test done");
        end_of_test();
    end
endmodule
`default_nettype wire

//--- ccr_sync.sv
// Two-flop synchroniser for a group of external levels
`timescale 1ns/1ps
`default_nettype none
module ccr_sync
    import ccr_pkg::*;
#(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire
